/* inc/ucs_cfg.svh */
// constants for the unsigned compare and right shift unit
`ifndef UCS_CFG_SVH
`define UCS_CFG_SVH

// ----------------------------------------------------------------------
// instruction fields
// ----------------------------------------------------------------------
`define UCS_OP_HI        31
`define UCS_OP_LO        26
`define UCS_FS_HI        25
`define UCS_FS_LO        21
`define UCS_SS_HI        20
`define UCS_SS_LO        16
`define UCS_RD_HI        15
`define UCS_RD_LO        11
`define UCS_SA_HI        10
`define UCS_SA_LO        6
`define UCS_FN_HI        5
`define UCS_FN_LO        0
`define UCS_IMM_HI       15

// ----------------------------------------------------------------------
// encodings
// ----------------------------------------------------------------------
`define UCS_OP_REG_CLASS 6'h00
`define UCS_OP_SLU_IMM   6'h0b
`define UCS_FN_SLU_REG   6'h2b
`define UCS_FN_SRA_IMM   6'h03
`define UCS_FN_SRA_VAR   6'h07
`define UCS_FN_SRL_IMM   6'h02
`define UCS_FN_SRL_VAR   6'h06

// ----------------------------------------------------------------------
// widths and reset values
// ----------------------------------------------------------------------
`define UCS_XLEN         64
`define UCS_WLEN         32
`define UCS_RES_RST      64'h0000_0000_0000_0000

`endif

/* inc/ucs_pkg.sv */
// types for the unsigned compare and right shift unit
package ucs_pkg;

  // ----------------------------------------------------------------------
  // operation select
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    UCS_OP_NONE   = 3'b000,
    UCS_OP_SLUI   = 3'b001,
    UCS_OP_SLUR   = 3'b010,
    UCS_OP_SRAI   = 3'b011,
    UCS_OP_SHIFT_RIGHT_ARITH_VAR   = 3'b100,
    UCS_OP_SRLI   = 3'b101,
    UCS_OP_SHIFT_RIGHT_LOGIC_VAR   = 3'b110
  } ucs_op_e;

  // ----------------------------------------------------------------------
  // issue and result bundles
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic [31:0] instr;
    logic [63:0] first_source;
    logic [63:0] second_source;
  } ucs_issue_s;

  typedef struct packed {
    logic        valid;
    logic [4:0]  dest;
    logic [63:0] data;
  } ucs_result_s;

endpackage

/* rtl/ucs_unit.sv */
// execute stage for unsigned compares and 32-bit right shifts
`timescale 1ns/1ps
`include "ucs_cfg.svh"

module ucs_unit
  import ucs_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        reset_n_i,
  // mode
  input  wire logic        mode_64_i,
  // issue from the pipeline
  input  wire ucs_issue_s  issue_i,
  // write back
  output ucs_result_s      result_o,
  output logic             illegal_o,
  output logic             overflow_o
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // widened compare: an extra zero on top keeps borrow out of the sign
  function automatic logic less_unsigned(input logic [63:0] a,
                                         input logic [63:0] b);
    logic [64:0] diff;
    diff = {1'b0, a} - {1'b0, b};
    return diff[64];
  endfunction

  // word shift then width fix-up shared by all four shifts
  function automatic logic [63:0] shift_word(input logic [31:0] w,
                                             input logic [4:0]  cnt,
                                             input logic        arith,
                                             input logic        m64);
    logic [31:0] t;
    t = arith ? 32'($signed(w) >>> cnt) : (w >> cnt);
    return m64 ? {{32{t[31]}}, t} : {32'h0000_0000, t};
  endfunction

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  logic [5:0]  opcode;
  logic [5:0]  func;
  logic [4:0]  shamt;
  logic [4:0]  fs_field;
  ucs_op_e     op;
  logic [4:0]  dest;

  assign opcode   = issue_i.instr[`UCS_OP_HI:`UCS_OP_LO];
  assign func     = issue_i.instr[`UCS_FN_HI:`UCS_FN_LO];
  assign shamt    = issue_i.instr[`UCS_SA_HI:`UCS_SA_LO];
  assign fs_field = issue_i.instr[`UCS_FS_HI:`UCS_FS_LO];

  // reserved zero fields are not looked at, so nonzero values are ignored
  always_comb begin
    op   = UCS_OP_NONE;
    dest = issue_i.instr[`UCS_RD_HI:`UCS_RD_LO];
    if (opcode == `UCS_OP_SLU_IMM) begin
      op   = UCS_OP_SLUI;
      dest = issue_i.instr[`UCS_SS_HI:`UCS_SS_LO];
    end else if (opcode == `UCS_OP_REG_CLASS) begin
      if (func == `UCS_FN_SLU_REG) begin
        op = UCS_OP_SLUR;
      end else if (func == `UCS_FN_SRA_IMM) begin
        op = UCS_OP_SRAI;
      end else if (func == `UCS_FN_SRA_VAR) begin
        op = UCS_OP_SHIFT_RIGHT_ARITH_VAR;
      end else if (func == `UCS_FN_SRL_IMM) begin
        op = UCS_OP_SRLI;
      end else if (func == `UCS_FN_SRL_VAR) begin
        op = UCS_OP_SHIFT_RIGHT_LOGIC_VAR;
      end
    end
  end

  // ----------------------------------------------------------------------
  // execute
  // ----------------------------------------------------------------------
  logic [63:0] imm_ext;
  logic [63:0] src_a;
  logic [63:0] exec_data;
  logic [31:0] word;
  logic [4:0]  var_cnt;

  // 32-bit mode compares only the low word, zero on top
  assign src_a   = mode_64_i ? issue_i.first_source
                             : {32'h0000_0000, issue_i.first_source[31:0]};
  assign imm_ext = mode_64_i
    ? {{48{issue_i.instr[`UCS_IMM_HI]}}, issue_i.instr[15:0]}
    : {32'h0000_0000, {16{issue_i.instr[`UCS_IMM_HI]}},
       issue_i.instr[15:0]};
  assign word    = issue_i.second_source[31:0];
  assign var_cnt = issue_i.first_source[4:0];

  always_comb begin
    logic [63:0] src_b;
    src_b     = mode_64_i ? issue_i.second_source
                          : {32'h0000_0000, issue_i.second_source[31:0]};
    exec_data = `UCS_RES_RST;
    case (op)
      UCS_OP_SLUI: exec_data = {63'h0, less_unsigned(src_a, imm_ext)};
      UCS_OP_SLUR: exec_data = {63'h0, less_unsigned(src_a, src_b)};
      UCS_OP_SRAI: exec_data = shift_word(word, shamt, 1'b1, mode_64_i);
      UCS_OP_SHIFT_RIGHT_ARITH_VAR: exec_data = shift_word(word, var_cnt, 1'b1, mode_64_i);
      UCS_OP_SRLI: exec_data = shift_word(word, shamt, 1'b0, mode_64_i);
      UCS_OP_SHIFT_RIGHT_LOGIC_VAR: exec_data = shift_word(word, var_cnt, 1'b0, mode_64_i);
      default:     exec_data = `UCS_RES_RST;
    endcase
  end

  // ----------------------------------------------------------------------
  // result register
  // ----------------------------------------------------------------------
  ucs_result_s res_reg;
  ucs_result_s res_next;
  logic        ill_reg;
  logic        ill_next;

  // one-cycle latency; unknown instructions flag illegal and write nothing
  always_comb begin
    res_next       = '0;
    ill_next       = 1'b0;
    if (issue_i.valid) begin
      if (op != UCS_OP_NONE) begin
        res_next.valid = 1'b1;
        res_next.dest  = dest;
        res_next.data  = exec_data;
      end else begin
        ill_next = 1'b1;
      end
    end
    // fs_field unused by the immediate shifts by design
    if (fs_field == 5'h00) begin
      ill_next = ill_next;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      res_reg <= '0;
      ill_reg <= 1'b0;
    end else begin
      res_reg <= res_next;
      ill_reg <= ill_next;
    end
  end

  assign result_o   = res_reg;
  assign illegal_o  = ill_reg;
  assign overflow_o = 1'b0;

endmodule

/* testbench/ucs_unit_assertions.sv */
// checker for the unsigned compare and right shift unit
`timescale 1ns/1ps
`include "ucs_cfg.svh"
module ucs_unit_assertions
  import ucs_pkg::*;
(
  // watched ports
  input wire logic        clk_sys_i,
  input wire logic        reset_n_i,
  input wire logic        mode_64_i,
  input wire ucs_issue_s  issue_i,
  input wire ucs_result_s result_o,
  input wire logic        illegal_o,
  input wire logic        overflow_o
);
  logic [31:0] i;
  logic [31:0] w;
  logic [63:0] a, b, x, e;
  logic        rc, lti, ltr;
  // reference values, taken from the issue before the edge that accepts it
  always_comb begin
    i = issue_i.instr;
    a = issue_i.first_source;
    b = issue_i.second_source;
    rc = i[31:26] == `UCS_OP_REG_CLASS;
    x = {{48{i[15]}}, i[15:0]};
    lti = mode_64_i ? a < x : a[31:0] < x[31:0];
    ltr = mode_64_i ? a < b : a[31:0] < b[31:0];
    w = b[31:0] >> (i[2] ? a[4:0] : i[10:6]);
    if (i[0]) w = $signed(b[31:0]) >>> (i[2] ? a[4:0] : i[10:6]);
    e = mode_64_i ? {{32{w[31]}}, w} : {32'h0, w};
  end
  // ----------------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------------
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  a_imm_compare: assert property (issue_i.valid && !rc && i[31:26] ==
    `UCS_OP_SLU_IMM |=> result_o.dest == $past(i[20:16])
    && result_o.data == {63'h0, $past(lti)}) else $error("imm compare");
  a_reg_compare: assert property (issue_i.valid && rc && i[5:0] ==
    `UCS_FN_SLU_REG |=> result_o.dest == $past(i[15:11])
    && result_o.data == {63'h0, $past(ltr)}) else $error("reg compare");
  a_arith_shift: assert property (issue_i.valid && rc && (i[5:0] ==
    `UCS_FN_SRA_IMM || i[5:0] == `UCS_FN_SRA_VAR) |=> result_o.valid
    && result_o.data == $past(e)) else $error("arith shift");
  a_logic_shift: assert property (issue_i.valid && rc && (i[5:0] ==
    `UCS_FN_SRL_IMM || i[5:0] == `UCS_FN_SRL_VAR) |=> result_o.valid
    && result_o.data == $past(e)) else $error("logic shift");
  a_upper_half: assert property (issue_i.valid && mode_64_i && rc
    && !i[5] && i[1] |=> result_o.data[63:32] == {32{result_o.data[31]}})
    else $error("upper half");
  a_overflow_low: assert property (overflow_o == 1'b0)
    else $error("overflow raised");
  a_one_answer: assert property (issue_i.valid |=>
    result_o.valid != illegal_o) else $error("answer count");
  a_quiet_idle: assert property (!issue_i.valid |=>
    !result_o.valid && !illegal_o) else $error("spurious answer");
  c_set_one: cover property (result_o.valid && result_o.data == 64'h1);
  c_illegal: cover property (illegal_o);
  c_back2back: cover property (issue_i.valid ##1 issue_i.valid);
endmodule
bind ucs_unit ucs_unit_assertions i_chk (.clk_sys_i, .reset_n_i,
  .mode_64_i, .issue_i, .result_o, .illegal_o, .overflow_o);

/* testbench/ucs_pipe_model.sv */
// pipeline and register file model feeding the unit
`timescale 1ns/1ps
module ucs_pipe_model
  import ucs_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        reset_n_i,
  // request from the bench, result back from the unit
  input  wire ucs_issue_s  req_i,
  input  wire ucs_result_s result_i,
  // issue toward the unit
  output ucs_issue_s       issue_o
);
  logic [63:0] general_register_file [32];
  // operands read by field, so junk in reserved fields reaches the unit
  always_comb begin
    issue_o = req_i;
    issue_o.first_source = general_register_file[req_i.instr[25:21]];
    issue_o.second_source = general_register_file[req_i.instr[20:16]];
  end
  // write back lands after the unit has already sampled the next issue
  always_ff @(posedge clk_sys_i) begin
    if (reset_n_i && result_i.valid) general_register_file[result_i.dest] <= result_i.data;
  end
endmodule

/* testbench/ucs_unit_bench.sv */
// self-checking bench for the unsigned compare and right shift unit
`timescale 1ns/1ps
module ucs_unit_bench;
  import ucs_pkg::*;
  logic        clk_sys_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        mode_64_i = 1'b0;
  ucs_issue_s  req = '0;
  ucs_issue_s  issue;
  ucs_result_s res;
  logic        ill, ovf;
  logic [63:0] seed = 64'h3593;
  logic [5:0]  fns [6] = '{6'h2b, 6'h03, 6'h07, 6'h02, 6'h06, 6'h2a};
  int          num_errors = 0;
  int          tests_run = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  ucs_pipe_model i_model (.clk_sys_i, .reset_n_i, .req_i(req),
    .result_i(res), .issue_o(issue));
  ucs_unit i_dut (.clk_sys_i, .reset_n_i, .mode_64_i, .issue_i(issue),
    .result_o(res), .illegal_o(ill), .overflow_o(ovf));
  // xorshift source, fixed start so every run repeats
  function automatic logic [63:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 7;
    seed ^= seed << 17;
    return seed;
  endfunction
  // random instruction; imm shifts carry junk in the zero source field
  function automatic logic [31:0] mk(logic [63:0] r);
    logic [5:0] f;
    if (r[34:32] % 3'h7 == 3'h6) return {6'h0b, 5'h01, 5'h02, r[15:0]};
    f = fns[r[34:32] % 3'h7];
    return {6'h00, f[2] | f[5] ? 5'h01 : r[25:21], 5'h02, r[15:6], f};
  endfunction
  // expected write-back value
  function automatic logic [63:0] ex(logic [31:0] i, logic [63:0] a,
                                     logic [63:0] b, logic m);
    logic [31:0] w;
    w = b[31:0] >> (i[2] ? a[4:0] : i[10:6]);
    if (i[0]) w = $signed(b[31:0]) >>> (i[2] ? a[4:0] : i[10:6]);
    if (i[31:26] != 6'h00) b = {{48{i[15]}}, i[15:0]};
    if (i[31:26] != 6'h00 || i[5:0] == 6'h2b)
      return {63'h0, m ? a < b : a[31:0] < b[31:0]};
    return m ? {{32{w[31]}}, w} : {32'h0, w};
  endfunction
  task automatic chk(string nm, logic [63:0] e, logic [63:0] s);
    tests_run++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH %s exp %h got %h", nm, e, s);
    end
  endtask
  // issue at a falling edge, look at the answer one cycle later
  task automatic go(logic [31:0] i, logic [63:0] a, logic [63:0] b,
                    logic m);
    logic bad;
    bad = i[31:26] == 6'h00 && i[5:0] == 6'h2a;
    i_model.general_register_file[1] = a;
    i_model.general_register_file[2] = b;
    mode_64_i = m;
    req = '{1'b1, i, 64'h0, 64'h0};
    @(negedge clk_sys_i);
    chk("valid", {63'h0, !bad}, {63'h0, res.valid});
    chk("overflow", 64'h0, {63'h0, ovf});
    if (!bad) chk("dest", {59'h0, i[31:26] != 6'h00 ? i[20:16] :
      i[15:11]}, {59'h0, res.dest});
    if (!bad) chk("data", ex(i, a, b, m), res.data);
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    logic [63:0] r;
    repeat (2) @(negedge clk_sys_i);
    reset_n_i = 1'b1;
    go({16'h2c22, 16'h8000}, 64'hffff_ffff_ffff_7fff, 64'h0, 1'b1);
    go({16'h2c22, 16'h8000}, 64'h8000_0000, 64'h0, 1'b0);
    go({16'h0022, 16'h482b}, 64'h0, '1, 1'b1);
    go({16'h0002, 16'h4fc3}, 64'h0, 64'h8000_0000, 1'b1);
    repeat (400) begin
      r = rnd();
      go(mk(r), rnd(), rnd(), r[63]);
    end
    req.valid = 1'b0;
    @(negedge clk_sys_i);
    chk("idle", 64'h0, {63'h0, res.valid | ill});
    wrap_up();
  end
endmodule
